/* File: design/lsra_regs.svh */
// register map, control word codes and timing counts for the lane shutdown and rate adjust block
`ifndef LSRA_REGS_SVH
`define LSRA_REGS_SVH

// register byte offsets
`define LSRA_CTRL_OFS        4'h0
`define LSRA_STATUS_OFS      4'h4
`define LSRA_ERRCNT_OFS      4'h8

// control register fields
`define LSRA_CTRL_START_BIT  0
`define LSRA_CTRL_AUTO_BIT   1
`define LSRA_CTRL_RST        2'h0

// status register fields
`define LSRA_STAT_STATE_LSB  0
`define LSRA_STAT_FILL_LSB   8

// word layout: bit 8 marks a control word
`define LSRA_WORD_W          9
`define LSRA_CW_IDLE         9'h1bc
`define LSRA_CW_IDLE_INV     9'h143
`define LSRA_CW_SKIP         9'h11c
`define LSRA_CW_SKIP_INV     9'h1e3
`define LSRA_CW_STANDBY      9'h1f7
`define LSRA_CW_LOST         9'h1fb
`define LSRA_CW_ERRWORD      9'h100

// counts
`define LSRA_NOTICE_COUNT    32
`define LSRA_RUN_LIMIT       8
`define LSRA_SKIP_PERIOD     5000
`define LSRA_LEAK_PERIOD     16384
`define LSRA_ERR_LIMIT       255
`define LSRA_WORD_DIV        8
`define LSRA_BUF_DEPTH       16

`endif

/* File: design/lsra_pkg.sv */
// types shared by the lane shutdown and rate adjust block
package lsra_pkg;
    typedef enum logic [2:0] {
        line_quiet_state,
        active_state,
        shutdown_announce_state,
        signal_lost_state,
        full_reset_state
    } lsra_state_t;
endpackage

/* File: design/lsra_lane.sv */
// lane shutdown states, skip insertion, receive elastic buffer and idle handling
//
// Register access over Avalon-MM and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "lsra_regs.svh"

module lsra_lane #(
    parameter int SKIP_PERIOD = `LSRA_SKIP_PERIOD,
    parameter int LEAK_PERIOD = `LSRA_LEAK_PERIOD,
    parameter int WORD_DIV = `LSRA_WORD_DIV,
    parameter int DEPTH = `LSRA_BUF_DEPTH
) (
    // clock, reset, enable
    input wire logic clock_in,
    input wire logic rstn_in,
    input wire logic ce_in,
    // avalon-mm slave
    input wire logic [3:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    // lane resets and status
    input wire logic full_reset_input_in,
    input wire logic partial_reset_input_in,
    input wire logic no_signal_in,
    input wire logic bring_up_done_in,
    output lsra_pkg::lsra_state_t state_out,
    // serial link side
    input wire logic link_clk_in,
    input wire logic [`LSRA_WORD_W-1:0] link_word_in,
    output logic [`LSRA_WORD_W-1:0] tx_word_out,
    output logic tx_enable_out,
    // upper layer side
    input wire logic [`LSRA_WORD_W-1:0] tx_data_in,
    input wire logic tx_valid_in,
    output logic tx_ready_out,
    output logic [`LSRA_WORD_W-1:0] rx_data_out,
    output logic rx_valid_out
);
    import lsra_pkg::*;

    localparam int WW = `LSRA_WORD_W;
    localparam int AW = $clog2(DEPTH);
    localparam int SW = $clog2(SKIP_PERIOD);
    localparam int LW = $clog2(LEAK_PERIOD);
    localparam int DW = $clog2(WORD_DIV);
    localparam logic [AW:0] FULL_FILL = (AW+1)'(DEPTH);
    localparam logic [AW:0] HALF_FILL = (AW+1)'(DEPTH / 2);
    localparam logic [5:0] LAST_NOTICE = 6'(`LSRA_NOTICE_COUNT - 1);
    localparam logic [3:0] RUN_LIMIT = 4'(`LSRA_RUN_LIMIT);
    localparam logic [7:0] ERR_LIMIT = 8'(`LSRA_ERR_LIMIT);

    typedef struct packed {
        lsra_state_t state;
        logic rxc1;
        logic rxc2;
        logic rxc3;
        logic [WW-1:0] rxd1;
        logic [WW-1:0] rxd2;
        logic ns1;
        logic ns2;
        logic [DEPTH-1:0][WW-1:0] mem;
        logic [AW:0] wr;
        logic [AW:0] rd;
        logic skip_held;
        logic [DW-1:0] div;
        logic [SW-1:0] skip_cnt;
        logic [LW-1:0] leak_cnt;
        logic [7:0] err_cnt;
        logic [5:0] notice_cnt;
        logic [3:0] run_sb;
        logic [3:0] run_ls;
        logic err_sent;
        logic lane_start;
        logic auto_start;
        logic waitreq;
        logic [31:0] readdata;
        logic [WW-1:0] tx_word;
        logic tx_en;
        logic tx_ready;
        logic [WW-1:0] rx_word;
        logic rx_valid;
    } lsra_regs_t;

    lsra_regs_t r;
    lsra_regs_t next_r;
    logic [AW:0] fill;
    logic tick;
    logic run8;

    // skip and its inverted form look alike to the reader
    function automatic logic is_skip(input logic [WW-1:0] w);
        is_skip = (w == `LSRA_CW_SKIP) || (w == `LSRA_CW_SKIP_INV);
    endfunction

    function automatic logic is_idle(input logic [WW-1:0] w);
        is_idle = (w == `LSRA_CW_IDLE) || (w == `LSRA_CW_IDLE_INV);
    endfunction

    // both pointers live in the local domain, so the difference is exact
    assign fill = r.wr - r.rd;
    assign tick = (r.div == DW'(WORD_DIV - 1));
    assign run8 = (r.run_sb >= RUN_LIMIT) || (r.run_ls >= RUN_LIMIT);

    always_comb begin
        logic [WW-1:0] head;
        logic [WW-1:0] got;
        logic have;
        next_r = r;
        head = r.mem[r.rd[AW-1:0]];
        got = head;
        have = 1'b0;
        next_r.tx_ready = 1'b0;
        next_r.rx_valid = 1'b0;

        // bus slave: one wait cycle, then a single cycle with waitrequest low
        if (!r.waitreq) begin
            next_r.waitreq = 1'b1;
            if (avs_write_in && avs_address_in == `LSRA_CTRL_OFS) begin
                next_r.lane_start = avs_writedata_in[`LSRA_CTRL_START_BIT];
                next_r.auto_start = avs_writedata_in[`LSRA_CTRL_AUTO_BIT];
            end
        end else if (avs_read_in || avs_write_in) begin
            next_r.waitreq = 1'b0;
            next_r.readdata = 32'h0000_0000;
            if (avs_address_in == `LSRA_CTRL_OFS) begin
                next_r.readdata[`LSRA_CTRL_START_BIT] = r.lane_start;
                next_r.readdata[`LSRA_CTRL_AUTO_BIT] = r.auto_start;
            end else if (avs_address_in == `LSRA_STATUS_OFS) begin
                next_r.readdata[`LSRA_STAT_STATE_LSB +: 3] = r.state;
                next_r.readdata[`LSRA_STAT_FILL_LSB +: AW+1] = fill;
            end else if (avs_address_in == `LSRA_ERRCNT_OFS) begin
                next_r.readdata[7:0] = r.err_cnt;
            end
        end

        // two-stage synchronisers for the link clock, link word and no-signal pin
        next_r.rxc1 = link_clk_in;
        next_r.rxc2 = r.rxc1;
        next_r.rxc3 = r.rxc2;
        next_r.rxd1 = link_word_in;
        next_r.rxd2 = r.rxd1;
        next_r.ns1 = no_signal_in;
        next_r.ns2 = r.ns1;

        // write side of the elastic buffer, one entry per rising recovered clock edge unless the buffer is full
        if (r.rxc2 && !r.rxc3 && fill != FULL_FILL) begin
            next_r.mem[r.wr[AW-1:0]] = r.rxd2;
            next_r.wr = r.wr + 1'b1;
        end

        next_r.div = tick ? '0 : r.div + 1'b1;

        if (tick) begin
            // read side: one word per local word slot; skips are dropped with the entry behind them or read twice to absorb the rate mismatch
            if (fill != '0) begin
                if (is_skip(head)) begin
                    if (r.skip_held) begin
                        next_r.rd = r.rd + 1'b1;
                        next_r.skip_held = 1'b0;
                    end else if (fill > HALF_FILL) begin
                        next_r.rd = r.rd + 1'b1;
                        if (fill > (AW+1)'(1)) begin
                            got = r.mem[next_r.rd[AW-1:0]];
                            next_r.rd = r.rd + 2'd2;
                            have = !is_skip(got) && !is_idle(got);
                        end
                    end else begin
                        next_r.skip_held = 1'b1;
                    end
                end else if (is_idle(head)) begin
                    next_r.rd = r.rd + 1'b1;
                end else begin
                    next_r.rd = r.rd + 1'b1;
                    have = 1'b1;
                end
            end

            // received word bookkeeping
            if (have) begin
                if (got == `LSRA_CW_STANDBY) begin
                    next_r.run_sb = (r.run_sb < RUN_LIMIT) ? r.run_sb + 1'b1 : r.run_sb;
                    next_r.run_ls = '0;
                end else if (got == `LSRA_CW_LOST) begin
                    next_r.run_ls = (r.run_ls < RUN_LIMIT) ? r.run_ls + 1'b1 : r.run_ls;
                    next_r.run_sb = '0;
                end else begin
                    next_r.run_sb = '0;
                    next_r.run_ls = '0;
                    if (r.state == active_state) begin
                        next_r.rx_word = got;
                        next_r.rx_valid = 1'b1;
                    end
                end
                // leaky bucket only runs while active
                if (r.state == active_state) begin
                    if (got == `LSRA_CW_ERRWORD && r.err_cnt != ERR_LIMIT) begin
                        next_r.err_cnt = r.err_cnt + 1'b1;
                    end
                    if (r.leak_cnt == LW'(LEAK_PERIOD - 1)) begin
                        next_r.leak_cnt = '0;
                        if (r.err_cnt != '0 && got != `LSRA_CW_ERRWORD) begin
                            next_r.err_cnt = r.err_cnt - 1'b1;
                        end
                    end else begin
                        next_r.leak_cnt = r.leak_cnt + 1'b1;
                    end
                end
            end

            // transmit word slot
            next_r.tx_word = `LSRA_CW_IDLE;
            case (r.state)
                active_state: begin
                    if (r.skip_cnt == SW'(SKIP_PERIOD - 1)) begin
                        next_r.skip_cnt = '0;
                        next_r.tx_word = `LSRA_CW_SKIP;
                    end else begin
                        next_r.skip_cnt = r.skip_cnt + 1'b1;
                        if (tx_valid_in) begin
                            next_r.tx_word = tx_data_in;
                            next_r.tx_ready = 1'b1;
                        end
                    end
                    // otherwise the idle default fills the slot
                end
                shutdown_announce_state: begin
                    next_r.tx_word = `LSRA_CW_STANDBY;
                    next_r.notice_cnt = r.notice_cnt + 1'b1;
                end
                signal_lost_state: begin
                    next_r.tx_word = `LSRA_CW_LOST;
                    next_r.notice_cnt = r.notice_cnt + 1'b1;
                    if (!r.err_sent) begin
                        next_r.rx_word = `LSRA_CW_ERRWORD;
                        next_r.rx_valid = 1'b1;
                        next_r.err_sent = 1'b1;
                    end
                end
                default: begin
                end
            endcase
        end

        // state machine: exits checked every cycle in their listed order
        case (r.state)
            full_reset_state: begin
                if (!full_reset_input_in) begin
                    next_r.state = line_quiet_state;
                end
            end
            line_quiet_state: begin
                if (full_reset_input_in) begin
                    next_r.state = full_reset_state;
                end else if (bring_up_done_in && !partial_reset_input_in) begin
                    next_r.state = active_state;
                    next_r.err_cnt = '0;
                    next_r.leak_cnt = '0;
                    next_r.run_sb = '0;
                    next_r.run_ls = '0;
                end
            end
            active_state: begin
                if (full_reset_input_in) begin
                    next_r.state = full_reset_state;
                end else if (partial_reset_input_in) begin
                    next_r.state = line_quiet_state;
                end else if (r.ns2 || r.err_cnt == ERR_LIMIT) begin
                    next_r.state = signal_lost_state;
                end else if (!r.lane_start && !r.auto_start) begin
                    next_r.state = shutdown_announce_state;
                end else if (run8) begin
                    next_r.state = line_quiet_state;
                end
                next_r.notice_cnt = '0;
                next_r.err_sent = 1'b0;
            end
            default: begin
                if (full_reset_input_in) begin
                    next_r.state = full_reset_state;
                end else if (partial_reset_input_in) begin
                    next_r.state = line_quiet_state;
                end else if (tick && r.notice_cnt == LAST_NOTICE) begin
                    next_r.state = line_quiet_state;
                end else if (run8) begin
                    next_r.state = line_quiet_state;
                end
            end
        endcase
        next_r.tx_en = (next_r.state == active_state) || (next_r.state == shutdown_announce_state)
            || (next_r.state == signal_lost_state);
    end

    // single state register; the enable freezes everything
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            r <= '0;
            r.waitreq <= 1'b1;
        end else if (ce_in) begin
            r <= next_r;
        end
    end

    assign avs_readdata_out = r.readdata;
    assign avs_waitrequest_out = r.waitreq;
    assign state_out = r.state;
    assign tx_word_out = r.tx_word;
    assign tx_enable_out = r.tx_en;
    assign tx_ready_out = r.tx_ready;
    assign rx_data_out = r.rx_word;
    assign rx_valid_out = r.rx_valid;

    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rstn_in);

    sequence last_notice_s;
        r.state == shutdown_announce_state && ce_in && tick && r.notice_cnt == LAST_NOTICE
            && !full_reset_input_in && !partial_reset_input_in;
    endsequence

    sequence lost_first_slot_s;
        r.state == signal_lost_state && ce_in && tick && !r.err_sent;
    endsequence

    announce_entry_a: assert property (
        r.state == active_state ##1 r.state == shutdown_announce_state
            |-> $past(!r.lane_start) && $past(!r.auto_start))
        else $error("shutdown announce entered with bring-up still requested");
    announce_count_a: assert property (
        last_notice_s |=> r.state == line_quiet_state && r.tx_word == `LSRA_CW_STANDBY)
        else $error("announce did not end after the last standby word");
    full_first_a: assert property (
        (r.state == shutdown_announce_state || r.state == signal_lost_state) && ce_in
            && full_reset_input_in |=> r.state == full_reset_state)
        else $error("full reset did not win in a shutdown state");
    run_exit_a: assert property (
        r.state == signal_lost_state && ce_in && run8 && !full_reset_input_in
            && !partial_reset_input_in |=> r.state == line_quiet_state)
        else $error("eight received notices did not end the shutdown state");
    nosig_lost_a: assert property (
        r.state == active_state && ce_in && r.ns2 && !full_reset_input_in
            && !partial_reset_input_in |=> r.state == signal_lost_state)
        else $error("no-signal did not move active to signal-lost");
    bucket_lost_a: assert property (
        r.state == active_state && ce_in && r.err_cnt == ERR_LIMIT && !full_reset_input_in
            && !partial_reset_input_in |=> r.state == signal_lost_state)
        else $error("error bucket overflow did not move to signal-lost");
    lost_errword_a: assert property (
        lost_first_slot_s |=> r.rx_valid && r.rx_word == `LSRA_CW_ERRWORD && r.tx_word == `LSRA_CW_LOST)
        else $error("signal-lost did not pass an error word up");
    skip_insert_a: assert property (
        r.state == active_state && ce_in && tick && r.skip_cnt == SW'(SKIP_PERIOD - 1)
            |=> r.tx_word == `LSRA_CW_SKIP && !r.tx_ready)
        else $error("skip word missing at the end of the period");
    skip_twice_a: assert property (
        r.skip_held && ce_in && tick && fill != '0 |=> !r.skip_held && r.rd == $past(r.rd) + 1'b1)
        else $error("held skip word was read a third time");
    filler_a: assert property (
        r.state == active_state && ce_in && tick && !tx_valid_in && r.skip_cnt != SW'(SKIP_PERIOD - 1)
            && next_r.state == active_state |=> r.tx_word == `LSRA_CW_IDLE && r.tx_en)
        else $error("no idle word in an empty active slot");
    skip_drop_a: assert property (
        ce_in && tick && !r.skip_held && is_skip(r.mem[r.rd[AW-1:0]]) && fill > HALF_FILL |=> r.rd == $past(r.rd) + 2'd2)
        else $error("skip above half fill was not dropped with the entry behind it");
    skip_keep_a: assert property (
        ce_in && tick && !r.skip_held && fill != '0 && is_skip(r.mem[r.rd[AW-1:0]]) && fill <= HALF_FILL
            |=> r.skip_held && r.rd == $past(r.rd))
        else $error("skip at or below half fill was not kept for a repeat read");
endmodule
`default_nettype wire

/* File: dv/lsra_far_end.sv */
// far-end lane endpoint model: free-running recovered link clock and word stream
`timescale 1ns/1ps
`default_nettype none
`include "lsra_regs.svh"

module lsra_far_end #(
    parameter int SKIP_EVERY = 20
) (
    // link side
    output logic link_clk_out,
    output logic [`LSRA_WORD_W-1:0] link_word_out
);
    logic [`LSRA_WORD_W-1:0] words_q[$];
    int cnt = 0;

    // same nominal rate as the near end, phase unrelated to the local clock
    initial begin
        link_clk_out = 1'b0;
        link_word_out = `LSRA_CW_IDLE;
        #137;
        forever #400 link_clk_out = ~link_clk_out;
    end

    // launch on the falling edge so the word is settled at the rising one
    always @(negedge link_clk_out) begin
        cnt <= (cnt + 1) % SKIP_EVERY;
        if (cnt == SKIP_EVERY - 1) begin
            link_word_out <= `LSRA_CW_SKIP;
        end else if (words_q.size() > 0) begin
            link_word_out <= words_q.pop_front();
        end else begin
            link_word_out <= `LSRA_CW_IDLE;
        end
    end

    task automatic send(input logic [`LSRA_WORD_W-1:0] w);
        words_q.push_back(w);
    endtask

    task automatic flush();
        words_q.delete();
    endtask
endmodule
`default_nettype wire

/* File: dv/tb_top.sv */
// self-checking bench for the lane shutdown and rate adjust block
`timescale 1ns/1ps
`default_nettype none
`include "lsra_regs.svh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin fail_count++; $display("[FAIL] t=%0t mismatch", $time); end end

module tb_top;
    import lsra_pkg::*;
    localparam int SKIP_P = 20;
    localparam int LIMIT = 20000;
    localparam logic [8:0] FILL[4] = '{`LSRA_CW_IDLE, `LSRA_CW_IDLE_INV, `LSRA_CW_SKIP, `LSRA_CW_SKIP_INV};
    logic clock_in = 1'b0, rstn_in = 1'b0, avs_read_in = 1'b0, avs_write_in = 1'b0;
    logic [3:0] avs_address_in = 4'h0;
    logic [31:0] avs_writedata_in = 32'h0000_0000, avs_readdata_out;
    logic avs_waitrequest_out, link_clk_in, tx_enable_out, tx_ready_out, rx_valid_out;
    logic full_reset_input_in = 1'b0, partial_reset_input_in = 1'b0, no_signal_in = 1'b0, bring_up_done_in = 1'b0;
    lsra_state_t state_out;
    logic [8:0] link_word_in, tx_word_out, rx_data_out, tx_data_in = 9'h000, note_word = 9'h000;
    logic tx_valid_in = 1'b0, prev_act = 1'b0, rx_chk = 1'b1, ce_in = 1'b1;
    int fail_count = 0, tests_run = 0, cycles = 0, div = 0, skip_cnt = 0, note_cnt = 0;
    logic [8:0] txq[$], rxq[$];
    logic [31:0] rdq[$];

    lsra_lane #(.SKIP_PERIOD(SKIP_P), .LEAK_PERIOD(16)) i_lsra_lane (.clock_in, .rstn_in, .ce_in,
        .avs_address_in, .avs_read_in, .avs_write_in, .avs_writedata_in, .avs_readdata_out, .avs_waitrequest_out,
        .full_reset_input_in, .partial_reset_input_in, .no_signal_in, .bring_up_done_in, .state_out,
        .link_clk_in, .link_word_in, .tx_word_out, .tx_enable_out, .tx_data_in, .tx_valid_in, .tx_ready_out,
        .rx_data_out, .rx_valid_out);
    lsra_far_end u_far (.link_clk_out(link_clk_in), .link_word_out(link_word_in));

    always #50 clock_in = ~clock_in;

    // hang guard, slot phase and result monitors; the slot is sampled mid-way, clear of updates
    always @(posedge clock_in) begin
        cycles <= cycles + 1;
        // the slot phase stands still with the design while the enable is low
        div <= !rstn_in ? 0 : ce_in ? (div + 1) % 8 : div;
        if (avs_read_in && avs_waitrequest_out === 1'b0) `CHK(avs_readdata_out, rdq.pop_front())
        if (rx_valid_out === 1'b1 && rx_chk) `CHK(rx_data_out, rxq.pop_front())
        if (div == 3 && ce_in) begin
            if (state_out == active_state && prev_act) begin
                if (tx_word_out === `LSRA_CW_SKIP) skip_cnt++;
                else if (tx_word_out[8] === 1'b0) `CHK(tx_word_out, txq.pop_front())
                else `CHK(tx_word_out, `LSRA_CW_IDLE)
            end
            if (state_out != active_state && tx_word_out === note_word) note_cnt++;
            prev_act <= (state_out == active_state);
        end
        if (cycles == LIMIT) begin
            fail_count++;
            test_done();
        end
    end

    task automatic test_done();
        $display("checks %0d, failures %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // one avalon transfer: request held until the edge that sees waitrequest low
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        @(posedge clock_in);
        avs_address_in <= a;
        avs_writedata_in <= d;
        avs_read_in <= !wr;
        avs_write_in <= wr;
        // no local limit: only the bench timeout ends a hung transfer
        do begin
            @(posedge clock_in);
        end while (avs_waitrequest_out !== 1'b0);
        avs_read_in <= 1'b0;
        avs_write_in <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        rdq.push_back(e);
        bus(1'b0, a, 32'h0000_0000);
    endtask

    task automatic wait_st(input lsra_state_t s, input int max, output int n);
        n = 0;
        while (state_out !== s && n < max) begin
            @(posedge clock_in);
            n++;
        end
        `CHK(state_out, s)
    endtask

    task automatic go_active();
        int n;
        bus(1'b1, 4'h0, 32'h0000_0003);
        bring_up_done_in <= 1'b1;
        wait_st(active_state, 50, n);
        bring_up_done_in <= 1'b0;
    endtask

    task automatic put_tx(input logic [8:0] w);
        txq.push_back(w);
        @(posedge clock_in);
        tx_data_in <= w;
        tx_valid_in <= 1'b1;
        do begin
            @(posedge clock_in);
        end while (tx_ready_out !== 1'b1);
        tx_valid_in <= 1'b0;
    endtask

    // shutdown state timing: duration in cycles and notice words seen
    task automatic notice_run(input logic [8:0] nw, output int n);
        note_word = nw;
        note_cnt = 0;
        wait_st(line_quiet_state, 300, n);
        `CHK(n inside {[242:263]}, 1'b1)
        `CHK(note_cnt inside {31, 32}, 1'b1)
        `CHK(tx_enable_out, 1'b0)
    endtask

    initial begin
        int n;
        logic [8:0] w;
        n = $urandom(32'h96db);
        repeat (10) @(posedge clock_in);
        rstn_in <= 1'b1;
        `CHK(state_out, line_quiet_state)
        `CHK(avs_waitrequest_out, 1'b1)
        `CHK(tx_enable_out, 1'b0)
        rd(4'h8, 32'h0000_0000);
        bus(1'b1, 4'h8, 32'hffff_ffff);
        rd(4'h8, 32'h0000_0000);
        bus(1'b1, 4'h0, 32'h0000_0003);
        rd(4'h0, 32'h0000_0003);
        rd(4'hc, 32'h0000_0000);
        go_active();
        `CHK(tx_enable_out, 1'b1)
        // receive data mixed with fillers of both polarities
        for (int i = 0; i < 12; i++) begin
            w = {1'b0, 8'($urandom)};
            rxq.push_back(w);
            u_far.send(w);
            u_far.send(FILL[i % 4]);
        end
        while (div != 0) @(posedge clock_in);
        skip_cnt = 0;
        fork
            for (int i = 0; i < 6; i++) put_tx({1'b0, 8'($urandom)});
            repeat (800) @(posedge clock_in);
        join
        `CHK(skip_cnt, 100 / SKIP_P)
        `CHK(rxq.size(), 0)
        `CHK(txq.size(), 0)
        // one enable bit alone keeps the lane active
        for (int v = 1; v < 3; v++) begin
            bus(1'b1, 4'h0, 32'(v));
            repeat (40) @(posedge clock_in);
            `CHK(state_out, active_state)
        end
        bus(1'b1, 4'h0, 32'h0000_0000);
        wait_st(shutdown_announce_state, 5, n);
        notice_run(`LSRA_CW_STANDBY, n);
        go_active();
        rxq.push_back(`LSRA_CW_ERRWORD);
        no_signal_in <= 1'b1;
        wait_st(signal_lost_state, 10, n);
        no_signal_in <= 1'b0;
        notice_run(`LSRA_CW_LOST, n);
        `CHK(rxq.size(), 0)
        // eight received lost words cut the announce burst short
        go_active();
        bus(1'b1, 4'h0, 32'h0000_0000);
        wait_st(shutdown_announce_state, 5, n);
        repeat (8) u_far.send(`LSRA_CW_LOST);
        wait_st(line_quiet_state, 300, n);
        `CHK(n < 200, 1'b1)
        // error words fill the leaky bucket until it overflows
        go_active();
        rx_chk = 1'b0;
        repeat (300) u_far.send(`LSRA_CW_ERRWORD);
        wait_st(signal_lost_state, 3000, n);
        partial_reset_input_in <= 1'b1;
        wait_st(line_quiet_state, 4, n);
        partial_reset_input_in <= 1'b0;
        u_far.flush();
        repeat (400) @(posedge clock_in);
        rx_chk = 1'b1;
        // both resets together: the full reset takes priority
        go_active();
        // a low enable freezes every register, so even a full reset request is ignored
        ce_in <= 1'b0;
        full_reset_input_in <= 1'b1;
        @(posedge clock_in);
        w = tx_word_out;
        repeat (12) @(posedge clock_in);
        `CHK(tx_word_out, w)
        `CHK(state_out, active_state)
        `CHK(tx_enable_out, 1'b1)
        ce_in <= 1'b1;
        full_reset_input_in <= 1'b0;
        bus(1'b1, 4'h0, 32'h0000_0000);
        wait_st(shutdown_announce_state, 5, n);
        full_reset_input_in <= 1'b1;
        partial_reset_input_in <= 1'b1;
        wait_st(full_reset_state, 4, n);
        test_done();
    end
endmodule
`default_nettype wire
